// File: ccc_consts.vh
`ifndef CCC_CONSTS_VH
`define CCC_CONSTS_VH

// Instruction cycle phases.
`define CCC_PH_DECODE  2'h0
`define CCC_PH_READ    2'h1
`define CCC_PH_PROCESS 2'h2
`define CCC_PH_WRITE   2'h3

// Opcode patterns and the instruction word fields they use.
`define CCC_CALL_TOP     3'h7
`define CCC_ZERO_TOP     7'h14
`define CCC_INV_TOP      7'h09
`define CCC_CMPEQ_TOP    8'h31
`define CCC_WDCLR_WORD   16'h0004
`define CCC_NOP_WORD     16'h0000

// Instruction word field positions.
`define CCC_F_TOP3       15:13
`define CCC_F_TOP7       15:9
`define CCC_F_TOP8       15:8
`define CCC_F_DEST       8
`define CCC_F_FILE       7:0
`define CCC_F_LIT        12:0
`define CCC_F_LHI        12:8
`define CCC_F_PAGE       15:13
`define CCC_DATA_W       8

// Reset values.
`define CCC_PC_RESET     16'h0000
`define CCC_BYTE_ZERO    8'h00
`define CCC_BYTE_ONES    8'hff
`define CCC_PC_STEP      16'h0001
`define CCC_STAT_RESET   1'b1
`define CCC_ZF_RESET     1'b0
`define CCC_FLAG_SET     1'b1

`endif

// File: ccc_exec.v
// How it works
// - Top bits 111 decode as short call; literal loads program counter bits 12:0.
// - Short call pushes program counter plus one before the counter changes.
// - Short call copies literal 12:8 and counter 15:13 into the latch high.
// - Short call takes two cycles, second is a no-op, flags stay unchanged.
// - Zero-file clears the register; with s zero it also clears working register.
// - Watchdog-clear zeroes counter and postscaler and sets timeout and power-down flags.
// - Invert-file complements the register to working or file; only zero flag changes.
// - Compare-skip-equal compares unsigned, writes nothing and changes no flag.
// - On equality the fetched next instruction is discarded and a no-op runs.
`timescale 1ns/1ps
`include "ccc_consts.vh"

module ccc_exec (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rstn_i,
  // Program memory
  output reg  [15:0] prog_addr_o,
  input  wire [15:0] instr_i,
  // Data memory file
  output wire [7:0]  file_addr_o,
  input  wire [7:0]  file_rd_data_i,
  output reg         file_wr_o,
  output reg  [7:0]  file_wr_data_o,
  // Hardware stack
  output reg         stack_push_o,
  output reg  [15:0] stack_head_o,
  // Watchdog
  output reg         watchdog_clear_o,
  // Core state
  output reg  [7:0]  working_register_o,
  output reg  [7:0]  program_counter_latch_high_o,
  output reg         zero_flag_o,
  output reg         timeout_flag_o,
  output reg         power_down_flag_o,
  output wire [1:0]  phase_o
);

  // Phase codes of the four-clock instruction cycle.
  localparam [1:0] PH_DECODE  = `CCC_PH_DECODE;
  localparam [1:0] PH_READ    = `CCC_PH_READ;
  localparam [1:0] PH_PROCESS = `CCC_PH_PROCESS;
  localparam [1:0] PH_WRITE   = `CCC_PH_WRITE;

  reg  [1:0]  phase_r;
  reg  [1:0]  phase_nxt;
  reg  [15:0] ir_r;
  reg         flush_r;
  reg         hold_pc_r;
  reg  [7:0]  opnd_r;
  reg  [7:0]  result_r;
  reg         equal_r;
  reg  [15:0] pc_nxt;
  wire [7:0]  inv_bits;

  wire is_call  = (ir_r[`CCC_F_TOP3] == `CCC_CALL_TOP);
  wire is_zero  = (ir_r[`CCC_F_TOP7] == `CCC_ZERO_TOP);
  wire is_inv   = (ir_r[`CCC_F_TOP7] == `CCC_INV_TOP);
  wire is_cmpeq = (ir_r[`CCC_F_TOP8] == `CCC_CMPEQ_TOP);
  wire is_wdclr = (ir_r == `CCC_WDCLR_WORD);
  wire dest_bit = ir_r[`CCC_F_DEST];

  assign file_addr_o = ir_r[`CCC_F_FILE];
  assign phase_o     = phase_r;

  // Phase sequencer: a plain binary walk through the four phases.
  always @* begin
    case (phase_r)
      PH_DECODE: begin
        phase_nxt = PH_READ;
      end
      PH_READ: begin
        phase_nxt = PH_PROCESS;
      end
      PH_PROCESS: begin
        phase_nxt = PH_WRITE;
      end
      PH_WRITE: begin
        phase_nxt = PH_DECODE;
      end
      default: begin
        phase_nxt = PH_DECODE;
      end
    endcase
  end

  // One inverter per data bit; the result is registered in the process phase.
  genvar bit_g;
  generate
    for (bit_g = 0; bit_g < `CCC_DATA_W; bit_g = bit_g + 1) begin : g_inv
      assign inv_bits[bit_g] = ~opnd_r[bit_g];
    end
  endgenerate

  // Next program counter. The slot after a call holds the counter, so the
  // freshly loaded target is fetched next instead of being stepped over.
  always @* begin
    pc_nxt = prog_addr_o + `CCC_PC_STEP;
    if (hold_pc_r) begin
      pc_nxt = prog_addr_o;
    end else if (is_call) begin
      pc_nxt = {prog_addr_o[`CCC_F_PAGE], ir_r[`CCC_F_LIT]};
    end
  end

  // Instruction register and slot sequencing.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      phase_r   <= `CCC_PH_DECODE;
      ir_r      <= `CCC_NOP_WORD;
      flush_r   <= 1'b0;
      hold_pc_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      case (phase_r)
        PH_DECODE: begin
          // A flushed slot latches the no-op word, so every later phase idles.
          if (flush_r) begin
            ir_r <= `CCC_NOP_WORD;
          end else begin
            ir_r <= instr_i;
          end
          flush_r <= 1'b0;
        end
        PH_WRITE: begin
          if (hold_pc_r) begin
            hold_pc_r <= 1'b0;
          end else if (is_call) begin
            flush_r   <= 1'b1;
            hold_pc_r <= 1'b1;
          end
          if (is_cmpeq && equal_r) begin
            flush_r <= 1'b1;
          end
        end
        default: begin
          flush_r <= flush_r;
        end
      endcase
    end
  end

  // Operand fetch and processing.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      opnd_r   <= `CCC_BYTE_ZERO;
      result_r <= `CCC_BYTE_ZERO;
      equal_r  <= 1'b0;
    end else begin
      if (phase_r == PH_READ) begin
        opnd_r <= file_rd_data_i;
      end
      if (phase_r == PH_PROCESS) begin
        // A zero unsigned difference is plain equality of the two bytes.
        equal_r <= (opnd_r == working_register_o);
        if (is_inv) begin
          result_r <= inv_bits;
        end else begin
          result_r <= `CCC_BYTE_ZERO;
        end
      end
    end
  end

  // Return address push. The program counter still holds the call's own
  // address here, since it only moves at write-back.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      stack_push_o <= 1'b0;
      stack_head_o <= `CCC_PC_RESET;
    end else begin
      stack_push_o <= 1'b0;
      if ((phase_r == PH_READ) && is_call) begin
        stack_push_o <= 1'b1;
        stack_head_o <= prog_addr_o + `CCC_PC_STEP;
      end
    end
  end

  // Program counter and latch high, both updated at write-back only.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      prog_addr_o                  <= `CCC_PC_RESET;
      program_counter_latch_high_o <= `CCC_BYTE_ZERO;
    end else if (phase_r == PH_WRITE) begin
      prog_addr_o <= pc_nxt;
      if (is_call && !hold_pc_r) begin
        program_counter_latch_high_o <= {prog_addr_o[`CCC_F_PAGE], ir_r[`CCC_F_LHI]};
      end
    end
  end

  // The watchdog and its status flags sit apart, since no other instruction
  // of this slice touches them.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      watchdog_clear_o  <= 1'b0;
      timeout_flag_o    <= `CCC_STAT_RESET;
      power_down_flag_o <= `CCC_STAT_RESET;
    end else begin
      watchdog_clear_o <= 1'b0;
      if ((phase_r == PH_PROCESS) && is_wdclr) begin
        watchdog_clear_o  <= 1'b1;
        timeout_flag_o    <= `CCC_FLAG_SET;
        power_down_flag_o <= `CCC_FLAG_SET;
      end
    end
  end

  // Write-back of the working register, the file and the zero flag.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      file_wr_o          <= 1'b0;
      file_wr_data_o     <= `CCC_BYTE_ZERO;
      working_register_o <= `CCC_BYTE_ZERO;
      zero_flag_o        <= `CCC_ZF_RESET;
    end else begin
      file_wr_o <= 1'b0;
      if (phase_r == PH_WRITE) begin
        if (is_zero) begin
          file_wr_o      <= 1'b1;
          file_wr_data_o <= result_r;
          if (!dest_bit) begin
            working_register_o <= result_r;
          end
        end
        if (is_inv) begin
          zero_flag_o <= (result_r == `CCC_BYTE_ZERO);
          if (dest_bit) begin
            file_wr_o      <= 1'b1;
            file_wr_data_o <= result_r;
          end else begin
            working_register_o <= result_r;
          end
        end
      end
    end
  end

endmodule // ccc_exec

// File: ccc_exec_chk.sv
`timescale 1ns/1ps
module ccc_exec_chk (
  input wire        clock_i,
  input wire        rstn_i,
  input wire [15:0] prog_addr_o,
  input wire        file_wr_o,
  input wire        stack_push_o,
  input wire [15:0] stack_head_o,
  input wire        watchdog_clear_o,
  input wire [7:0]  program_counter_latch_high_o,
  input wire        timeout_flag_o,
  input wire        power_down_flag_o,
  input wire [1:0]  phase_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  chk_phase_step: assert property (phase_o != 2'h3 |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase order broken");
  chk_pc_hold: assert property (phase_o != 2'h3 |=> $stable(prog_addr_o))
    else $error("program counter moved mid cycle");
  chk_push_value: assert property (stack_push_o |-> phase_o == 2'h2 && stack_head_o == prog_addr_o + 16'h1)
    else $error("bad push");
  chk_push_once: assert property (stack_push_o |=> !stack_push_o [*7])
    else $error("second push");
  chk_call_latch: assert property (stack_push_o |-> ##2 program_counter_latch_high_o == prog_addr_o[15:8] && prog_addr_o[15:13] == $past(prog_addr_o[15:13], 2))
    else $error("bad call target");
  chk_call_idle: assert property (stack_push_o |-> ##3 (!file_wr_o && $stable(prog_addr_o)) [*4])
    else $error("call second cycle not idle");
  chk_wd_flags: assert property (watchdog_clear_o |-> phase_o == 2'h3 && timeout_flag_o && power_down_flag_o)
    else $error("bad watchdog clear");
  chk_write_pulse: assert property (file_wr_o |-> phase_o == 2'h0 ##1 !file_wr_o)
    else $error("bad write pulse");
  cover property (stack_push_o);
  cover property (watchdog_clear_o);
  cover property (file_wr_o);
endmodule // ccc_exec_chk
bind ccc_exec ccc_exec_chk chk_u (.*);

// File: ccc_prog_mem.sv
`timescale 1ns/1ps
module ccc_prog_mem (
  input  wire  [15:0] addr_i,
  output logic [15:0] data_o
);
  // Only the low address bits decode, so the call target 1108 folds onto slot 8.
  always_comb begin
    case (addr_i[3:0])
      4'h0: data_o = 16'h0004;
      4'h1: data_o = 16'h1210;
      4'h2: data_o = 16'h2910;
      4'h3: data_o = 16'h1311;
      4'h4: data_o = 16'h3112;
      4'h5: data_o = 16'h2800;
      4'h6: data_o = 16'hf108;
      4'h7: data_o = 16'h2800;
      4'h8: data_o = 16'h2811;
      4'h9: data_o = 16'h3112;
      4'ha: data_o = 16'h1210;
      default: data_o = 16'h0000;
    endcase
  end
endmodule // ccc_prog_mem

// File: ccc_exec_tb_top.sv
`timescale 1ns/1ps
module ccc_exec_tb_top;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  fd = 8'h00;
  int          err_total = 0;
  int          checked = 0;
  wire  [15:0] pa, ins, sh;
  wire  [7:0]  fwd, working_register, lh, fa;
  wire         fwr, push, wdc, zf, tf, pf;
  ccc_prog_mem pm_u (.addr_i(pa), .data_o(ins));
  ccc_exec dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .prog_addr_o(pa), .instr_i(ins),
    .file_addr_o(fa), .file_rd_data_i(fd), .file_wr_o(fwr), .file_wr_data_o(fwd),
    .stack_push_o(push), .stack_head_o(sh), .watchdog_clear_o(wdc),
    .working_register_o(working_register), .program_counter_latch_high_o(lh), .zero_flag_o(zf),
    .timeout_flag_o(tf), .power_down_flag_o(pf), .phase_o());
  initial forever #50 clock_i = ~clock_i;
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task run(input int n);
    repeat (4 * n) @(posedge clock_i);
    #1;
  endtask
  task t_wdclr;
    repeat (3) @(posedge clock_i);
    #1;
    chk(wdc, 16'h1);
    run(0);
    @(posedge clock_i);
    #1;
    chk(wdc, 16'h0);
    chk({tf, pf}, 16'h3);
    $display("wdclr done");
  endtask
  task t_invert;
    fd = 8'h13;
    run(1);
    chk({fwr, zf, working_register}, 16'h00ec);
    run(1);
    chk({fwr, fwd}, 16'h0100);
    chk(working_register, 16'h00ec);
    fd = 8'hff;
    run(1);
    chk({fwr, zf, fwd}, 16'h0300);
    chk(fa, 16'h0011);
    $display("invert done");
  endtask
  task t_compare;
    fd = 8'hec;
    run(1);
    chk({fwr, zf}, 16'h1);
    run(1);
    chk(pa, 16'h0006);
    chk(working_register, 16'h00ec);
    $display("compare done");
  endtask
  task t_call;
    run(1);
    chk(sh, 16'h0007);
    chk(pa, 16'h1108);
    chk({lh, 7'h0, zf}, 16'h1101);
    run(1);
    chk(pa, 16'h1108);
    run(1);
    chk({fwr, working_register}, 16'h0100);
    $display("call done");
  endtask
  task t_compare_ne;
    fd = 8'h5a;
    run(1);
    chk({fwr, zf}, 16'h0001);
    chk(fa, 16'h0012);
    run(1);
    chk(pa, 16'h110b);
    chk({zf, working_register}, 16'h00a5);
    $display("compare ne done");
  endtask
  task t_reset;
    rstn_i = 1'b0;
    run(1);
    chk(pa, 16'h0000);
    chk({lh, working_register}, 16'h0000);
    chk({fwr, push, wdc, tf, pf, zf}, 16'h0006);
    rstn_i = 1'b1;
    t_wdclr();
    $display("reset done");
  endtask
  task wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    t_wdclr();
    t_invert();
    t_compare();
    t_call();
    t_compare_ne();
    t_reset();
    wrap_up();
  end
endmodule // ccc_exec_tb_top
